// ===== core/lptc_params.svh
`ifndef LPTC_PARAMS_SVH
`define LPTC_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets (low 16 address bits)
// ----------------------------------------------------------------
`define LPTC_OFF_CTL      16'hf024
`define LPTC_OFF_CNT      16'hf028
`define LPTC_OFF_CMP0     16'hf02c
`define LPTC_OFF_CMP1     16'hf030
`define LPTC_OFF_CMP2     16'hf034
`define LPTC_OFF_FLAGS    16'hf038
`define LPTC_OFF_INTSTAT  16'hf03c

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define LPTC_CTL_RUN      0
`define LPTC_CTL_CLR      1
`define LPTC_CTL_PRE_LO   2
`define LPTC_CTL_PRE_HI   13
`define LPTC_CTL_TICK_IE  14
`define LPTC_CTL_CMP_IE   15
`define LPTC_CTL_OVF_IE   18
`define LPTC_CTL_TICK_EE  19
`define LPTC_CTL_CMP_EE   20
`define LPTC_CTL_OVF_EE   23

// ----------------------------------------------------------------
// reset values, key and timing
// ----------------------------------------------------------------
`define LPTC_CTL_RST      32'h00000000
`define LPTC_CNT_RST      24'h000000
`define LPTC_CMP_RST      24'h000000
`define LPTC_OVF_KEY      32'h5a5aa5a5
`define LPTC_OVF_LOAD     24'hfffff0
`define LPTC_CLK_HZ       50000000
`define LPTC_LF_HZ        32768
`define LPTC_LF_DIV       (`LPTC_CLK_HZ / `LPTC_LF_HZ)

`endif

// ===== core/lptc_pkg.sv
package lptc_pkg;

  // one bit per event source, also the layout of the interrupt status
  typedef struct packed {
    logic       ovf;
    logic [2:0] cmp;
    logic       tick;
  } lptc_evt_t;

  typedef enum logic [1:0] {
    LPTC_BUS_IDLE,
    LPTC_BUS_WR,
    LPTC_BUS_RD,
    LPTC_BUS_RDONE
  } lptc_bus_st_t;

endpackage

// ===== core/lptc_top.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "lptc_params.svh"
// Function
// R1: 24-bit up-counter fed through prescaler
// R2: 12-bit prescaler, rate 32768/(value+1)
// R3: bit 0 run/stop; prescaler locked while running
// R4: bit 1 clears counter, self-clears
// R5: bit 14 enables tick interrupt
// R6: bits 15-17 enable comparator interrupts
// R7: bit 18 enables overflow interrupt
// R8: bit 19 enables tick event output
// R9: bits 20-22 enable comparator event outputs
// R10: bit 23 enables overflow event output
// R11: counter read: low 24 bits, upper zero
// R12: key write loads counter with fffff0
// R13: three writable 24-bit compare values, reset zero
// R14: flag register: compare bits 0-2, overflow 3
// R15: tick generator on prescaled counter clock
// R16: counter equal compare value sets flag
// R17: wrap to zero sets overflow; tick per step
module lptc_top #(
  parameter int LF_DIV = `LPTC_LF_DIV
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  output logic                    irq,
  output lptc_pkg::lptc_evt_t     evt_out
);

  localparam int DIVW = (LF_DIV > 2) ? $clog2(LF_DIV) : 1;
  localparam int NCMP = 3;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  lptc_pkg::lptc_bus_st_t bus_st_reg;
  logic [15:0]            addr_reg;
  logic                   wsize_ok_reg;
  logic                   hready_reg;
  logic [31:0]            hrdata_reg;
  logic                   accept;
  logic                   wr_en;
  logic [31:0]            rd_mux;

  // reads take one wait state so the data word always comes from a flop
  // and already reflects a write finished on the accepting edge
  assign accept = hsel && htrans[1] && hready;
  assign wr_en  = (bus_st_reg == lptc_pkg::LPTC_BUS_WR) && wsize_ok_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_reg   <= lptc_pkg::LPTC_BUS_IDLE;
      addr_reg     <= 16'h0000;
      wsize_ok_reg <= 1'b0;
      hready_reg   <= 1'b1;
    end else begin
      unique case (bus_st_reg)
        lptc_pkg::LPTC_BUS_RD: begin
          bus_st_reg <= lptc_pkg::LPTC_BUS_RDONE;
          hready_reg <= 1'b1;
        end
        default: begin
          if (accept) begin
            bus_st_reg   <= hwrite ? lptc_pkg::LPTC_BUS_WR : lptc_pkg::LPTC_BUS_RD;
            addr_reg     <= haddr[15:0];
            wsize_ok_reg <= (hsize == 3'h2);
            hready_reg   <= hwrite;
          end else begin
            bus_st_reg <= lptc_pkg::LPTC_BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (bus_st_reg == lptc_pkg::LPTC_BUS_RD) begin
      hrdata_reg <= rd_mux;
    end
  end

  assign hreadyout = hready_reg;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [31:0] ctl_reg;
  logic        run;
  logic [11:0] presc_val;
  logic        ctl_wr;
  logic        cnt_wr;

  assign ctl_wr    = wr_en && (addr_reg == `LPTC_OFF_CTL);
  assign cnt_wr    = wr_en && (addr_reg == `LPTC_OFF_CNT);
  assign run       = ctl_reg[`LPTC_CTL_RUN];
  assign presc_val = ctl_reg[`LPTC_CTL_PRE_HI:`LPTC_CTL_PRE_LO];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_reg <= `LPTC_CTL_RST;
    end else if (ctl_wr) begin
      ctl_reg <= hwdata;
      if (run) begin
        ctl_reg[`LPTC_CTL_PRE_HI:`LPTC_CTL_PRE_LO] <= presc_val; // R3
      end
    end else if (ctl_reg[`LPTC_CTL_CLR]) begin
      ctl_reg[`LPTC_CTL_CLR] <= 1'b0; // R4
    end
  end

  // ----------------------------------------------------------------
  // low-frequency timebase and prescaler
  // ----------------------------------------------------------------
  logic [DIVW-1:0] lf_div_reg;
  logic            lf_tick;
  logic [11:0]     presc_reg;
  logic            cnt_step;

  // the 32768 hz rate is approximated by an integer divider of hclk
  assign lf_tick  = (lf_div_reg == DIVW'(LF_DIV - 1));
  // >= so a field lowered while stopped cannot strand the count above it
  assign cnt_step = lf_tick && run && (presc_reg >= presc_val); // R2

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lf_div_reg <= '0;
    end else if (lf_tick) begin
      lf_div_reg <= '0;
    end else begin
      lf_div_reg <= lf_div_reg + DIVW'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_reg <= 12'h000;
    end else if (ctl_reg[`LPTC_CTL_CLR]) begin
      presc_reg <= 12'h000;
    end else if (lf_tick && run) begin
      presc_reg <= cnt_step ? 12'h000 : presc_reg + 12'h001; // R2
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic [23:0] cnt_reg;
  logic [23:0] cnt_inc;
  logic        key_hit;

  assign cnt_inc = cnt_reg + 24'h000001;
  assign key_hit = cnt_wr && (hwdata == `LPTC_OVF_KEY);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= `LPTC_CNT_RST;
    end else if (ctl_reg[`LPTC_CTL_CLR]) begin
      cnt_reg <= `LPTC_CNT_RST; // R4
    end else if (key_hit) begin
      cnt_reg <= `LPTC_OVF_LOAD; // R12
    end else if (cnt_step) begin
      cnt_reg <= cnt_inc; // R1 R17
    end
  end

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  logic [23:0]         cmp_reg [NCMP];
  wire  [NCMP-1:0]     cmp_hit;
  lptc_pkg::lptc_evt_t evt_now;

  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi++) begin : g_cmp
      logic cmp_wr;
      assign cmp_wr = wr_en && (addr_reg == (`LPTC_OFF_CMP0 + 16'(4 * gi)));
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cmp_reg[gi] <= `LPTC_CMP_RST; // R13
        end else if (cmp_wr) begin
          cmp_reg[gi] <= hwdata[23:0]; // R13
        end
      end
      // match is taken on the step that makes the counter equal
      assign cmp_hit[gi] = cnt_step && (cnt_inc == cmp_reg[gi]); // R16
    end
  endgenerate

  // one driver for the whole event word; per-channel hits arrive on a net
  assign evt_now = {cnt_step && (cnt_reg == 24'hffffff), // R17
                    cmp_hit,
                    cnt_step}; // R15 R17

  // ----------------------------------------------------------------
  // status, interrupt and event outputs
  // ----------------------------------------------------------------
  lptc_pkg::lptc_evt_t status_reg;
  lptc_pkg::lptc_evt_t w1c;
  lptc_pkg::lptc_evt_t int_en;
  lptc_pkg::lptc_evt_t evt_en;

  assign w1c    = (wr_en && (addr_reg == `LPTC_OFF_INTSTAT)) ? hwdata[4:0] : 5'h00;
  assign int_en = {ctl_reg[`LPTC_CTL_OVF_IE],
                   ctl_reg[`LPTC_CTL_CMP_IE+2:`LPTC_CTL_CMP_IE],
                   ctl_reg[`LPTC_CTL_TICK_IE]}; // R5 R6 R7
  assign evt_en = {ctl_reg[`LPTC_CTL_OVF_EE],
                   ctl_reg[`LPTC_CTL_CMP_EE+2:`LPTC_CTL_CMP_EE],
                   ctl_reg[`LPTC_CTL_TICK_EE]}; // R8 R9 R10

  // a new event beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~w1c) | evt_now; // R16 R17
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & int_en); // R5 R6 R7
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_out <= '0;
    end else begin
      evt_out <= evt_now & evt_en; // R8 R9 R10
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (addr_reg)
      `LPTC_OFF_CTL:     rd_mux = ctl_reg;
      `LPTC_OFF_CNT:     rd_mux = {8'h00, cnt_reg}; // R11
      `LPTC_OFF_CMP0:    rd_mux = {8'h00, cmp_reg[0]};
      `LPTC_OFF_CMP1:    rd_mux = {8'h00, cmp_reg[1]};
      `LPTC_OFF_CMP2:    rd_mux = {8'h00, cmp_reg[2]};
      `LPTC_OFF_FLAGS:   rd_mux = {28'h0000000, status_reg.ovf, status_reg.cmp}; // R14
      `LPTC_OFF_INTSTAT: rd_mux = {27'h0000000, status_reg};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_rd_req(logic [15:0] a);
    accept && !hwrite && (haddr[15:0] == a);
  endsequence

  sequence s_rd_done;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_clr_self;
    @(posedge hclk) disable iff (!hresetn)
      (ctl_reg[`LPTC_CTL_CLR] && !ctl_wr) |=> (!ctl_reg[`LPTC_CTL_CLR] && cnt_reg == 24'h0);
  endproperty
  a_clr_self: assert property (p_clr_self) else $error("clear bit did not self-clear"); // R4

  property p_key_load;
    @(posedge hclk) disable iff (!hresetn)
      (key_hit && !ctl_reg[`LPTC_CTL_CLR]) |=> (cnt_reg == 24'hfffff0);
  endproperty
  a_key_load: assert property (p_key_load) else $error("key write did not preload"); // R12

  property p_presc_lock;
    @(posedge hclk) disable iff (!hresetn)
      (ctl_wr && run) |=> $stable(presc_val);
  endproperty
  a_presc_lock: assert property (p_presc_lock) else $error("prescaler changed while running"); // R3

  property p_stop_hold;
    @(posedge hclk) disable iff (!hresetn)
      (!run && !ctl_reg[`LPTC_CTL_CLR] && !key_hit) |=> $stable(cnt_reg);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped"); // R3

  property p_inc;
    @(posedge hclk) disable iff (!hresetn)
      (cnt_step && !ctl_reg[`LPTC_CTL_CLR] && !key_hit) |=> (cnt_reg == $past(cnt_reg) + 24'h1);
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not step by one"); // R1

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
      (evt_now.ovf && !ctl_reg[`LPTC_CTL_CLR] && !key_hit) |=> (cnt_reg == 24'h0 && status_reg.ovf);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not flag overflow"); // R17

  property p_cmp0_flag;
    @(posedge hclk) disable iff (!hresetn)
      (cnt_step && cnt_inc == cmp_reg[0]) |=> status_reg.cmp[0];
  endproperty
  a_cmp0_flag: assert property (p_cmp0_flag) else $error("compare 0 flag missed"); // R16

  property p_tick_evt;
    @(posedge hclk) disable iff (!hresetn)
      cnt_step |=> (evt_out.tick == $past(ctl_reg[`LPTC_CTL_TICK_EE]));
  endproperty
  a_tick_evt: assert property (p_tick_evt) else $error("tick event wrong"); // R8

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
      ((status_reg & int_en) != 5'h00) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled status did not raise irq"); // R5

  property p_rd_cnt;
    @(posedge hclk) disable iff (!hresetn)
      s_rd_req(`LPTC_OFF_CNT) |=> s_rd_done ##0 (hrdata[31:24] == 8'h00);
  endproperty
  a_rd_cnt: assert property (p_rd_cnt) else $error("counter read upper bits not zero"); // R11

  property p_rd_flags;
    @(posedge hclk) disable iff (!hresetn)
      s_rd_req(`LPTC_OFF_FLAGS) |=> s_rd_done ##0 (hrdata[31:4] == 28'h0000000);
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read upper bits not zero"); // R14

  property p_cmp_evt;
    @(posedge hclk) disable iff (!hresetn)
      evt_now.cmp[0] |=> (evt_out.cmp[0] == $past(ctl_reg[`LPTC_CTL_CMP_EE]));
  endproperty
  a_cmp_evt: assert property (p_cmp_evt) else $error("compare 0 event wrong"); // R9

  property p_ovf_evt;
    @(posedge hclk) disable iff (!hresetn)
      evt_now.ovf |=> (evt_out.ovf == $past(ctl_reg[`LPTC_CTL_OVF_EE]));
  endproperty
  a_ovf_evt: assert property (p_ovf_evt) else $error("overflow event wrong"); // R10

  property p_irq_mask;
    @(posedge hclk) disable iff (!hresetn)
      ((status_reg & int_en) == 5'h00) |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked status raised irq"); // R6 R7

  property p_cmp_wr;
    @(posedge hclk) disable iff (!hresetn)
      (wr_en && addr_reg == `LPTC_OFF_CMP1) |=>
        ({8'h00, cmp_reg[1]} == ($past(hwdata) & 32'h00ffffff));
  endproperty
  a_cmp_wr: assert property (p_cmp_wr) else $error("compare 1 write not stored"); // R13

endmodule // lptc_top

// ===== bench/lptc_top_bench.sv
`timescale 1ns/1ns
`include "lptc_params.svh"
module lptc_top_bench;
  logic                hclk;
  logic                hresetn;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  logic                irq;
  lptc_pkg::lptc_evt_t evt_out;
  int                  err_count;
  int                  num_checks;
  int                  evt_cnt [5];
  logic [31:0]         rd;
  logic [31:0]         v0;

  lptc_top #(.LF_DIV(4)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .evt_out(evt_out)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // event pulse counters, one per source
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    for (int i = 0; i < 5; i++) begin
      if (evt_out[i] === 1'b1) evt_cnt[i]++;
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // waits for hready sampled high; a bound that runs out ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic xfer(input logic wr, input logic [15:0] off, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {16'h4000, off};
    hsize  <= 3'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [15:0] off, input logic [31:0] d);
    xfer(1'b1, off, d);
  endtask

  task automatic rd_chk(input logic [15:0] off, input logic [31:0] exp);
    xfer(1'b0, off, 32'h0);
    check(rd, exp);
    check(hresp, 1'b0);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 400) begin
      err_count++;
      report_and_stop();
    end
  endtask

  // stops the counter and clears every sticky status bit
  task automatic quiesce();
    wr(`LPTC_OFF_CTL, 32'h0);
    wr(`LPTC_OFF_INTSTAT, 32'h1f);
    repeat (3) @(posedge hclk);
    check(irq, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    logic [15:0] offs [7];
    offs = '{`LPTC_OFF_CTL, `LPTC_OFF_CNT, `LPTC_OFF_CMP0, `LPTC_OFF_CMP1,
             `LPTC_OFF_CMP2, `LPTC_OFF_FLAGS, 16'hf040};
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
  endtask

  task automatic t_compare_regs();
    wr(`LPTC_OFF_CMP0, 32'hab123450);
    wr(`LPTC_OFF_CMP1, 32'hab123451);
    wr(`LPTC_OFF_CMP2, 32'hab123452);
    rd_chk(`LPTC_OFF_CMP0, 32'h00123450);
    rd_chk(`LPTC_OFF_CMP1, 32'h00123451);
    rd_chk(`LPTC_OFF_CMP2, 32'h00123452);
  endtask

  task automatic t_counter_key();
    wr(`LPTC_OFF_CNT, 32'h12345678);
    rd_chk(`LPTC_OFF_CNT, 32'h0);
    wr(`LPTC_OFF_CNT, 32'h5a5aa5a5);
    rd_chk(`LPTC_OFF_CNT, 32'h00fffff0);
    wr(`LPTC_OFF_CTL, 32'h2);
    rd_chk(`LPTC_OFF_CNT, 32'h0);
    rd_chk(`LPTC_OFF_CTL, 32'h0);
  endtask

  task automatic t_prescaler_lock();
    wr(`LPTC_OFF_CTL, 32'hd);
    rd_chk(`LPTC_OFF_CTL, 32'hd);
    wr(`LPTC_OFF_CTL, 32'h1d);
    rd_chk(`LPTC_OFF_CTL, 32'hd);
    wr(`LPTC_OFF_CTL, 32'h0);
    xfer(1'b0, `LPTC_OFF_CNT, 32'h0);
    v0 = rd;
    repeat (40) @(posedge hclk);
    rd_chk(`LPTC_OFF_CNT, v0);
    wr(`LPTC_OFF_CTL, 32'h0);
    rd_chk(`LPTC_OFF_CTL, 32'h0);
  endtask

  // prescaler 1 with lf tick every 4 cycles: one step per 8 cycles
  task automatic t_tick_rate();
    int t0;
    wr(`LPTC_OFF_CTL, 32'h2);
    wr(`LPTC_OFF_INTSTAT, 32'h1f);
    t0 = evt_cnt[0];
    wr(`LPTC_OFF_CTL, 32'h84005);
    xfer(1'b0, `LPTC_OFF_CNT, 32'h0);
    v0 = rd;
    repeat (158) @(posedge hclk);
    xfer(1'b0, `LPTC_OFF_CNT, 32'h0);
    check(rd - v0 >= 19 && rd - v0 <= 21, 1'b1);
    check(evt_cnt[0] - t0 >= 19, 1'b1);
    check(irq, 1'b1);
    quiesce();
  endtask

  task automatic t_compare_match();
    int c0;
    int c1;
    wr(`LPTC_OFF_CTL, 32'h2);
    wr(`LPTC_OFF_CMP0, 32'h3);
    wr(`LPTC_OFF_CMP1, 32'h6);
    c0 = evt_cnt[1];
    c1 = evt_cnt[2];
    wr(`LPTC_OFF_CTL, 32'h110001);
    wait_irq();
    rd_chk(`LPTC_OFF_FLAGS, 32'h3);
    check(evt_cnt[1] - c0, 32'h1);
    check(evt_cnt[2] - c1, 32'h0);
    quiesce();
    rd_chk(`LPTC_OFF_FLAGS, 32'h0);
  endtask

  task automatic t_overflow();
    int o0;
    int t0;
    o0 = evt_cnt[4];
    t0 = evt_cnt[0];
    wr(`LPTC_OFF_CNT, 32'h5a5aa5a5);
    wr(`LPTC_OFF_CTL, 32'h840001);
    wait_irq();
    wr(`LPTC_OFF_CTL, 32'h0);
    xfer(1'b0, `LPTC_OFF_FLAGS, 32'h0);
    check(rd[3], 1'b1);
    xfer(1'b0, `LPTC_OFF_CNT, 32'h0);
    check(rd < 32'h10, 1'b1);
    check(evt_cnt[4] - o0, 32'h1);
    check(evt_cnt[0] - t0, 32'h0);
    quiesce();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_compare_regs();
    t_counter_key();
    t_prescaler_lock();
    t_tick_rate();
    t_compare_match();
    t_overflow();
    report_and_stop();
  end
endmodule // lptc_top_bench
